// file: core/egress_event_pkg.sv
// Constants and carrier types for the mesh-stop egress event selector
package egress_event_pkg;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [3:0]  EVENT_SEL_OFFSET  = 4'h0;
  localparam logic [3:0]  EVENT_STAT_OFFSET = 4'h4;
  localparam logic [31:0] EVENT_SEL_RESET   = 32'h0000_0000;
  localparam int          CODE_LSB          = 0;
  localparam int          MASK_LSB          = 8;
  localparam int          KNOWN_BIT         = 31;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  // ****************************************************************
  // Event codes
  // ****************************************************************
  localparam logic [7:0] EV_HORIZ_OCCUPANCY   = 8'ha0;
  localparam logic [7:0] EV_HORIZ_ALLOCATIONS = 8'ha1;
  localparam logic [7:0] EV_HORIZ_FULL        = 8'ha2;
  localparam logic [7:0] EV_HORIZ_NONEMPTY    = 8'ha3;
  localparam logic [7:0] EV_HORIZ_NACKS       = 8'ha4;
  localparam logic [7:0] EV_HORIZ_STARVATION  = 8'ha5;
  localparam logic [7:0] EV_HORIZ_BYPASSES    = 8'ha7;
  localparam logic [7:0] EV_VERT_FULL         = 8'h94;
  localparam logic [7:0] EV_VERT_COREACK_FULL = 8'h95;
  localparam logic [7:0] EV_VERT_NONEMPTY     = 8'h96;
  localparam logic [7:0] EV_VERT_SLOT_USES    = 8'h9c;
  localparam logic [7:0] EV_VERT_BYPASSES     = 8'h9d;
  localparam logic [7:0] EV_VERT_COREACK_BYP  = 8'h9e;

  // ****************************************************************
  // Unit-mask bits that each event family honours
  // ****************************************************************
  // Horizontal: 0 req uncred, 1 ack, 2 data uncred, 3 snoop,
  // 4 req cred, 6 data cred, 7 core-ack uncred; bit 5 has no class
  localparam logic [7:0] HORIZ_VALID_MASK   = 8'hdf;
  localparam logic [7:0] STARVE_VALID_MASK  = 8'h8f;
  localparam logic [7:0] REQ_ALL_MASK       = 8'h11;
  localparam logic [7:0] DATA_ALL_MASK      = 8'h44;
  // Vertical: 0..3 req/ack/data/snoop agent 0, 4..6 req/ack/data agent 1
  localparam logic [6:0] VERT_VALID_MASK    = 7'h7f;
  localparam logic [6:0] SLOT_VALID_MASK    = 7'h55;
  localparam logic [1:0] COREACK_VALID_MASK = 2'h3;

  // ****************************************************************
  // Condition carriers
  // ****************************************************************
  localparam int OCC_WIDTH = 6;
  localparam int INC_WIDTH = OCC_WIDTH + 3;

  typedef struct packed {
    logic [7:0] full;
    logic [7:0] nonEmpty;
    logic [7:0] alloc;
    logic [7:0] nack;
    logic [7:0] starved;
    logic [7:0] bypass;
    logic [7:0][OCC_WIDTH-1:0] occupancy;
  } horiz_cond_type;

  typedef struct packed {
    logic [6:0] slotUse;
    logic [6:0] bypass;
    logic [6:0] full;
    logic [6:0] nonEmpty;
    logic [1:0] coreAckBypass;
    logic [1:0] coreAckFull;
  } vert_cond_type;

endpackage

// file: core/mesh_stop_egress_event_select.sv
// Egress event selector for a mesh stop with an AXI4-Lite register port
`timescale 1ns/1ps
`default_nettype none

module mesh_stop_egress_event_select (
  input  wire logic                            sys_clk,
  input  wire logic                            rst,
  input  wire logic                            awvalid,
  output var  logic                            awready,
  input  wire logic [31:0]                     awaddr,
  input  wire logic                            wvalid,
  output var  logic                            wready,
  input  wire logic [31:0]                     wdata,
  input  wire logic [3:0]                      wstrb,
  output var  logic                            bvalid,
  input  wire logic                            bready,
  output var  logic [1:0]                      bresp,
  input  wire logic                            arvalid,
  output var  logic                            arready,
  input  wire logic [31:0]                     araddr,
  output var  logic                            rvalid,
  input  wire logic                            rready,
  output var  logic [31:0]                     rdata,
  output var  logic [1:0]                      rresp,
  input  wire egress_event_pkg::horiz_cond_type horizCond,
  input  wire egress_event_pkg::vert_cond_type  vertCond,
  output var  logic [egress_event_pkg::INC_WIDTH-1:0] eventIncrement,
  output var  logic                            eventKnown
);
  import egress_event_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Nine bits hold eight single-bit conditions or eight six-bit
  // occupancies at their largest, so the sum never wraps
  // Count of set condition bits under the mask; both bits of one ring add
  function automatic logic [INC_WIDTH-1:0] maskedCount(input logic [7:0] sel,
                                                       input logic [7:0] cond);
    logic [INC_WIDTH-1:0] acc;
    acc = '0;
    for (int i = 0; i < 8; i++) begin
      acc = acc + INC_WIDTH'(sel[i] & cond[i]);
    end
    return acc;
  endfunction

  // Word-aligned register index check
  function automatic logic isReg(input logic [31:0] addr, input logic [3:0] off);
    return (addr[31:4] == 28'h0) && (addr[3:0] == off);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  logic [31:0]          eventSel_r,  eventSel_nxt;
  logic                 awHeld_r,    awHeld_nxt;
  logic [31:0]          awAddr_r,    awAddr_nxt;
  logic                 wHeld_r,     wHeld_nxt;
  logic [31:0]          wData_r,     wData_nxt;
  logic [3:0]           wStrb_r,     wStrb_nxt;
  logic                 awready_r,   awready_nxt;
  logic                 wready_r,    wready_nxt;
  logic                 bvalid_r,    bvalid_nxt;
  logic [1:0]           bresp_r,     bresp_nxt;
  logic                 arready_r,   arready_nxt;
  logic                 rvalid_r,    rvalid_nxt;
  logic [31:0]          rdata_r,     rdata_nxt;
  logic [1:0]           rresp_r,     rresp_nxt;
  logic [INC_WIDTH-1:0] increment_r, increment_nxt;
  logic                 known_r,     known_nxt;
  logic [7:0]           code;
  logic [7:0]           umask;

  // Code and mask come straight from the stored select word, so a new
  // selection reaches the decode in the cycle after the write lands
  // and the increment one edge after that
  assign code  = eventSel_r[CODE_LSB +: 8];
  assign umask = eventSel_r[MASK_LSB +: 8];

  // ****************************************************************
  // Event decode
  // ****************************************************************
  // Mask bits with no ring class behind them are stripped before the sum,
  // so a stray bit set by software cannot add a phantom count. A code
  // outside the table gives zero and drops the known flag, so the counter
  // never keeps adding a stale value from the code selected before.
  // The sum is registered, which keeps the long adder chain off the output.
  // Forms the per-cycle increment from the selected code and unit mask
  always_comb begin
    logic [7:0] hSel;
    logic [7:0] vSel;
    logic [7:0] cSel;
    hSel          = umask & HORIZ_VALID_MASK;
    vSel          = {1'b0, umask[6:0] & VERT_VALID_MASK};
    cSel          = {6'h0, umask[1:0] & COREACK_VALID_MASK};
    increment_nxt = '0;
    known_nxt     = 1'b1;
    unique case (code)
      EV_HORIZ_OCCUPANCY: begin
        for (int i = 0; i < 8; i++) begin
          if (hSel[i]) begin
            increment_nxt = increment_nxt
                          + INC_WIDTH'(horizCond.occupancy[i]);
          end
        end
      end
      EV_HORIZ_ALLOCATIONS: increment_nxt = maskedCount(hSel, horizCond.alloc);
      EV_HORIZ_FULL:        increment_nxt = maskedCount(hSel, horizCond.full);
      EV_HORIZ_NONEMPTY:    increment_nxt = maskedCount(hSel, horizCond.nonEmpty);
      EV_HORIZ_NACKS:       increment_nxt = maskedCount(hSel, horizCond.nack);
      EV_HORIZ_STARVATION: begin
        increment_nxt = maskedCount(umask & STARVE_VALID_MASK,
                                    horizCond.starved);
      end
      EV_HORIZ_BYPASSES:    increment_nxt = maskedCount(hSel, horizCond.bypass);
      EV_VERT_SLOT_USES: begin
        increment_nxt = maskedCount(vSel & {1'b0, SLOT_VALID_MASK},
                                    {1'b0, vertCond.slotUse});
      end
      EV_VERT_BYPASSES:     increment_nxt = maskedCount(vSel, {1'b0, vertCond.bypass});
      EV_VERT_COREACK_BYP: begin
        increment_nxt = maskedCount(cSel, {6'h0, vertCond.coreAckBypass});
      end
      EV_VERT_FULL:         increment_nxt = maskedCount(vSel, {1'b0, vertCond.full});
      EV_VERT_COREACK_FULL: begin
        increment_nxt = maskedCount(cSel, {6'h0, vertCond.coreAckFull});
      end
      EV_VERT_NONEMPTY:     increment_nxt = maskedCount(vSel, {1'b0, vertCond.nonEmpty});
      default:              known_nxt = 1'b0;
    endcase
  end

  // ****************************************************************
  // Register write channel
  // ****************************************************************
  // Each channel is held once taken until its partner arrives, and the
  // response is raised at the edge that takes the later one.
  // Both readies stay low while the response waits, so a second write
  // cannot overwrite the held address or data before the first is
  // answered; the readies return at the edge that takes the response.
  // Address and data are taken in either order; response follows both
  always_comb begin
    logic takeAw;
    logic takeW;
    logic [31:0] merged;
    takeAw       = awvalid & awready_r;
    takeW        = wvalid & wready_r;
    merged       = eventSel_r;
    awHeld_nxt   = awHeld_r | takeAw;
    awAddr_nxt   = takeAw ? awaddr : awAddr_r;
    wHeld_nxt    = wHeld_r | takeW;
    wData_nxt    = takeW ? wdata : wData_r;
    wStrb_nxt    = takeW ? wstrb : wStrb_r;
    eventSel_nxt = eventSel_r;
    bvalid_nxt   = bvalid_r & ~bready;
    bresp_nxt    = bresp_r;
    if (awHeld_nxt && wHeld_nxt && !bvalid_r) begin
      for (int b = 0; b < 4; b++) begin
        if (wStrb_nxt[b]) begin
          merged[b*8 +: 8] = wData_nxt[b*8 +: 8];
        end
      end
      if (isReg(awAddr_nxt, EVENT_SEL_OFFSET)) begin
        eventSel_nxt = merged;
        bresp_nxt    = RESP_OKAY;
      end else if (isReg(awAddr_nxt, EVENT_STAT_OFFSET)) begin
        bresp_nxt    = RESP_OKAY; // Status is read-only; write ignored
      end else begin
        bresp_nxt    = RESP_SLVERR;
      end
      bvalid_nxt = 1'b1;
      awHeld_nxt = 1'b0;
      wHeld_nxt  = 1'b0;
    end
    awready_nxt = ~awHeld_nxt & ~bvalid_nxt;
    wready_nxt  = ~wHeld_nxt & ~bvalid_nxt;
  end

  // ****************************************************************
  // Register read channel
  // ****************************************************************
  // Status returns the increment registered in the cycle before, the
  // value the counter has already been given, not the live decode.
  // Unmapped reads answer with zero data and an error response.
  // One read at a time; data returned the cycle after the address
  always_comb begin
    rvalid_nxt = rvalid_r & ~rready;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      if (isReg(araddr, EVENT_SEL_OFFSET)) begin
        rdata_nxt = eventSel_r;
      end else if (isReg(araddr, EVENT_STAT_OFFSET)) begin
        rdata_nxt            = 32'h0;
        rdata_nxt[INC_WIDTH-1:0] = increment_r;
        rdata_nxt[KNOWN_BIT] = known_r;
      end else begin
        rdata_nxt = 32'h0;
        rresp_nxt = RESP_SLVERR;
      end
    end
    arready_nxt = ~rvalid_nxt;
  end

  // ****************************************************************
  // Flip-flops
  // ****************************************************************
  // One register process per group, each with a synchronous reset.
  // Readies are low during reset and rise at the first edge after it.
  // Event stage: registered increment and known flag
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      increment_r <= '0;
      known_r     <= 1'b0;
    end else begin
      increment_r <= increment_nxt;
      known_r     <= known_nxt;
    end
  end

  // Write channel: select word, held address and data, readies, response
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      eventSel_r  <= EVENT_SEL_RESET;
      awHeld_r    <= 1'b0;
      awAddr_r    <= 32'h0;
      wHeld_r     <= 1'b0;
      wData_r     <= 32'h0;
      wStrb_r     <= 4'h0;
      awready_r   <= 1'b0;
      wready_r    <= 1'b0;
      bvalid_r    <= 1'b0;
      bresp_r     <= RESP_OKAY;
    end else begin
      eventSel_r  <= eventSel_nxt;
      awHeld_r    <= awHeld_nxt;
      awAddr_r    <= awAddr_nxt;
      wHeld_r     <= wHeld_nxt;
      wData_r     <= wData_nxt;
      wStrb_r     <= wStrb_nxt;
      awready_r   <= awready_nxt;
      wready_r    <= wready_nxt;
      bvalid_r    <= bvalid_nxt;
      bresp_r     <= bresp_nxt;
    end
  end

  // Read channel: ready, data and response
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      arready_r   <= 1'b0;
      rvalid_r    <= 1'b0;
      rdata_r     <= 32'h0;
      rresp_r     <= RESP_OKAY;
    end else begin
      arready_r   <= arready_nxt;
      rvalid_r    <= rvalid_nxt;
      rdata_r     <= rdata_nxt;
      rresp_r     <= rresp_nxt;
    end
  end

  // Every output is a flip-flop, so nothing on the pins depends
  // combinationally on the bus inputs or the condition inputs
  // Outputs straight from flip-flops
  assign awready        = awready_r;
  assign wready         = wready_r;
  assign bvalid         = bvalid_r;
  assign bresp          = bresp_r;
  assign arready        = arready_r;
  assign rvalid         = rvalid_r;
  assign rdata          = rdata_r;
  assign rresp          = rresp_r;
  assign eventIncrement = increment_r;
  assign eventKnown     = known_r;

endmodule

`default_nettype wire

// file: bench/egress_event_chk.sv
// Port-level checker for the egress event selector
`timescale 1ns/1ps
`default_nettype none

module egress_event_chk
  import egress_event_pkg::*;
(
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire logic                 awvalid,
  input wire logic                 awready,
  input wire logic                 wvalid,
  input wire logic                 wready,
  input wire logic                 bvalid,
  input wire logic                 bready,
  input wire logic [1:0]           bresp,
  input wire logic                 arvalid,
  input wire logic                 arready,
  input wire logic                 rvalid,
  input wire logic                 rready,
  input wire logic [31:0]          rdata,
  input wire horiz_cond_type       horizCond,
  input wire vert_cond_type        vertCond,
  input wire logic [INC_WIDTH-1:0] eventIncrement,
  input wire logic                 eventKnown
);
  // ****************************************************************
  // Bus handshake and event path properties
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  reset_quiet_a: assert property (disable iff (1'b0) rst |=> !awready && !arready && !bvalid
    && !rvalid && eventIncrement == '0 && !eventKnown) else $error("outputs busy after reset");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  write_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while response pending");
  read_block_a: assert property (rvalid |-> !arready)
    else $error("read accepted while data pending");
  write_answer_a: assert property (awvalid && awready && wvalid && wready |=> bvalid)
    else $error("no write response one cycle after both taken");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("no read data one cycle after address taken");
  bresp_done_a: assert property (bvalid && bready |=> !bvalid)
    else $error("write response repeated");
  unknown_zero_a: assert property (!eventKnown |-> eventIncrement == '0)
    else $error("increment from an undecoded code");
  idle_zero_a: assert property (horizCond == '0 && vertCond == '0 |=> eventIncrement == '0)
    else $error("increment without any condition");
endmodule

bind mesh_stop_egress_event_select egress_event_chk u_chk (.sys_clk(sys_clk), .rst(rst),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .rready(rready), .rdata(rdata), .horizCond(horizCond), .vertCond(vertCond),
  .eventIncrement(eventIncrement), .eventKnown(eventKnown));

`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench for the egress event selector
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import egress_event_pkg::*;
  logic                 sys_clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic                 arvalid, arready, rvalid, rready, eventKnown;
  logic [31:0]          awaddr, wdata, araddr, rdata, rd;
  logic [3:0]           wstrb;
  logic [1:0]           bresp, rresp, rs;
  logic [INC_WIDTH-1:0] eventIncrement;
  horiz_cond_type       horizCond;
  vert_cond_type        vertCond;
  int                   err_total, total_checks, cyc;
  // Rows: event code, unit mask, expected increment for the fixed conditions below
  localparam logic [24:0] TBL [21] = '{
    {8'ha2, 8'h11, 9'h002}, {8'ha2, 8'h02, 9'h000},
    {8'ha3, 8'h44, 9'h002}, {8'ha1, 8'h44, 9'h002},
    {8'ha1, 8'h11, 9'h000}, {8'ha4, 8'h80, 9'h001},
    {8'ha4, 8'h02, 9'h001}, {8'ha0, 8'h44, 9'h00a},
    {8'ha0, 8'h80, 9'h008}, {8'ha5, 8'hff, 9'h005},
    {8'ha5, 8'h10, 9'h000}, {8'ha7, 8'h08, 9'h001},
    {8'ha7, 8'h20, 9'h000}, {8'h9c, 8'hff, 9'h004},
    {8'h9c, 8'h02, 9'h000}, {8'h9d, 8'h0a, 9'h002},
    {8'h9d, 8'h80, 9'h000}, {8'h9e, 8'h01, 9'h000},
    {8'h9e, 8'h02, 9'h001}, {8'h55, 8'hff, 9'h000},
    {8'ha3, 8'hff, 9'h007}};
  localparam logic [24:0] TBV [4] = '{{8'h94, 8'h7f, 9'h003}, {8'h94, 8'h30, 9'h002},
    {8'h95, 8'h03, 9'h002}, {8'h96, 8'h40, 9'h001}};

  mesh_stop_egress_event_select DUT (.sys_clk(sys_clk), .rst(rst), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .horizCond(horizCond), .vertCond(vertCond),
    .eventIncrement(eventIncrement), .eventKnown(eventKnown));

  // ****************************************************************
  // Clock, hang guard and shared tasks
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Cuts a hang short
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[ERR] %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  // Write both channels together, release each as it is taken, take the response.
  // Handshakes are judged mid-cycle, where the registered readies stand until the edge.
  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
    logic tkA;
    logic tkW;
    logic tkB;
    r = RESP_OKAY;
    @(posedge sys_clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    bready  <= 1'b1;
    do begin
      @(negedge sys_clk);
      tkA = awvalid && awready;
      tkW = wvalid && wready;
      tkB = bvalid && bready;
      if (tkB) r = bresp;
      @(posedge sys_clk);
      if (tkA) awvalid <= 1'b0;
      if (tkW) wvalid <= 1'b0;
    end while (!tkB);
    bready <= 1'b0;
  endtask

  // Offer the address, release it when taken, take data mid-cycle in the cycle whose edge ends the read
  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic tkA;
    logic tkR;
    d = 32'h0;
    r = RESP_OKAY;
    @(posedge sys_clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(negedge sys_clk);
      tkA = arvalid && arready;
      tkR = rvalid && rready;
      if (tkR) begin
        d = rdata;
        r = rresp;
      end
      @(posedge sys_clk);
      if (tkA) arvalid <= 1'b0;
    end while (!tkR);
    rready <= 1'b0;
  endtask

  // Program a code and mask, let the decode settle, compare increment and known flag
  task automatic run(input logic [24:0] row);
    axw(32'h0, {16'h0, row[16:9], row[24:17]}, 4'hf, rs);
    repeat (3) @(posedge sys_clk);
    #1 chk(32'(eventIncrement), 32'(row[8:0]), "increment");
    chk(32'(eventKnown), 32'(row[24:17] != 8'h55), "code decode");
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    err_total = 0;
    total_checks = 0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'h0; horizCond = '0; vertCond = '0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    horizCond.full <= 8'h11; horizCond.nonEmpty <= 8'hff; horizCond.alloc <= 8'h44;
    horizCond.nack <= 8'h82; horizCond.starved <= 8'hff; horizCond.bypass <= 8'h28;
    for (int i = 0; i < 8; i++) horizCond.occupancy[i] <= 6'(i + 1);
    vertCond <= '{7'h7f, 7'h0a, 7'h31, 7'h7f, 2'h2, 2'h3};
    @(posedge sys_clk);
    axr(32'h0, rd, rs);
    chk(rd, EVENT_SEL_RESET, "select reset value");
    chk(32'(rs), 32'(RESP_OKAY), "select read response");
    axw(32'h0, 32'h1234_55a3, 4'hf, rs);
    axw(32'h0, 32'hffff_ff00, 4'h1, rs);
    axr(32'h0, rd, rs);
    chk(rd, 32'h1234_5500, "byte lane merge");
    axw(32'h4, 32'hffff_ffff, 4'hf, rs);
    chk(32'(rs), 32'(RESP_OKAY), "status write response");
    axr(32'h8, rd, rs);
    chk(rd, 32'h0, "unmapped read data");
    chk(32'(rs), 32'(RESP_SLVERR), "unmapped read response");
    axw(32'h10, 32'h0, 4'hf, rs);
    chk(32'(rs), 32'(RESP_SLVERR), "unmapped write");
    $display("register test done");
    foreach (TBV[i]) run(TBV[i]);
    foreach (TBL[i]) run(TBL[i]);
    axr(32'h4, rd, rs);
    chk(rd, 32'h8000_0007, "status word");
    horizCond <= '0; vertCond <= '0;
    repeat (3) @(posedge sys_clk);
    #1 chk(32'(eventIncrement), 32'h0, "idle increment");
    $display("event test done");
    close_out();
  end
endmodule

`default_nettype wire
